/* hdl/tpl_defines.svh */
`ifndef TPL_DEFINES_SVH
`define TPL_DEFINES_SVH

// register offsets, byte addresses on the plain register port
`define TPL_ADDR_CTRL      8'h00
`define TPL_ADDR_DOUT      8'h04
`define TPL_ADDR_LIM_ONE   8'h08
`define TPL_ADDR_LIM_TWO   8'h0C
`define TPL_ADDR_STATUS    8'h10
`define TPL_ADDR_IRQ_STAT  8'h14
`define TPL_ADDR_IRQ_MASK  8'h18
`define TPL_ADDR_CMD       8'h1C

// control register fields
`define TPL_CTRL_MODE_W    3
`define TPL_CTRL_PORT_W    4
`define TPL_CTRL_POL_BIT   3
`define TPL_CTRL_AUTO_BIT  8
`define TPL_CTRL_CLEAR_BIT 9

// limit register fields: lower, upper, threshold in percent
`define TPL_PCT_W          7
`define TPL_LIM_LO_LSB     0
`define TPL_LIM_HI_LSB     8
`define TPL_LIM_THR_LSB    16

// command register bits, write-one pulses
`define TPL_CMD_CLOSE_BIT  0
`define TPL_CMD_OPEN_BIT   1

// interrupt status bits
`define TPL_IRQ_W          4
`define TPL_IRQ_TOG_ONE    0
`define TPL_IRQ_TOG_TWO    1
`define TPL_IRQ_AUTO_OPEN  2
`define TPL_IRQ_LOOP_CHG   3

// reset values
`define TPL_RST_LO         7'h0A
`define TPL_RST_HI         7'h5A
`define TPL_RST_THR        7'h0A

// percentages are scaled against this full count
`define TPL_PCT_FULL       32'd100

`endif

/* hdl/tpl_pkg.sv */
package tpl_pkg;

   // port function selection
   typedef enum logic [2:0] {
      TPL_MODE_DISABLED = 3'h0,
      TPL_MODE_DIG_IN   = 3'h1,
      TPL_MODE_TOGGLE   = 3'h2,
      TPL_MODE_DIG_OUT  = 3'h3,
      TPL_MODE_WIN_OUT  = 3'h4,
      TPL_MODE_CTR_OUT  = 3'h5,
      TPL_MODE_BOTH_OUT = 3'h6
   } tpl_mode_t;

   // control loop operating state
   typedef enum logic {
      TPL_LOOP_OPEN   = 1'b0,
      TPL_LOOP_CLOSED = 1'b1
   } tpl_loop_t;

endpackage

/* hdl/tpl_cond_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tpl_cond_if #(
   parameter int W_SUM  = 12,
   parameter int W_DIFF = 16
);
   logic        [W_SUM-1:0]  sum;       // beam_intensity_total
   logic signed [W_DIFF-1:0] hoff;      // horizontal_offset
   logic signed [W_DIFF-1:0] voff;      // vertical_offset
   logic [1:0][6:0]          lo;        // intensity_lower_limit per port
   logic [1:0][6:0]          hi;        // intensity_upper_limit per port
   logic [1:0][6:0]          thr;       // centring_threshold per port
   logic [1:0]               win;       // intensity inside window
   logic [1:0]               ctr;       // both offsets below threshold
   logic                     below_lo;  // intensity under port one lower

   modport src  (output sum, hoff, voff, lo, hi, thr,
                 input  win, ctr, below_lo);
   modport eval (input  sum, hoff, voff, lo, hi, thr,
                 output win, ctr, below_lo);
endinterface
`default_nettype wire

/* hdl/tpl_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module tpl_sync #(
   parameter int N = 2
) (
   input  wire logic         clk_in,
   input  wire logic         arst_n_in,
   input  wire logic [N-1:0] d_in,
   output logic      [N-1:0] lvl_out,
   output logic      [N-1:0] rise_out,
   output logic      [N-1:0] fall_out
);
   generate
      if (N < 1) begin : g_chk
         $error("tpl_sync needs at least one bit");
      end
   endgenerate

   typedef struct packed {
      logic [N-1:0] s1;   // first stage, read only by s2
      logic [N-1:0] s2;   // settled level
      logic [N-1:0] s3;   // previous settled level
   } tpl_sync_t;

   tpl_sync_t st;
   tpl_sync_t next_st;

   // shift the chain; idle high matches the pull-up
   always_comb begin
      next_st    = st;
      next_st.s1 = d_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st <= '1;
      end else begin
         st <= next_st;
      end
   end

   // edges only from settled stages, one event per edge
   assign lvl_out  = st.s2;
   assign rise_out = st.s2 & ~st.s3;
   assign fall_out = ~st.s2 & st.s3;
endmodule
`default_nettype wire

/* hdl/tpl_cond.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tpl_defines.svh"
module tpl_cond #(
   parameter int W_SUM  = 12,
   parameter int W_DIFF = 16
) (
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   tpl_cond_if.eval  cif
);
   generate
      if (W_SUM < 2 || W_SUM > 24 || W_DIFF < 2 || W_DIFF > 24) begin : g_chk
         $error("tpl_cond widths must lie in 2..24");
      end
   endgenerate

   // full-scale counts; offsets are signed so half range
   localparam logic [31:0] SUM_FS  = 32'((64'd1 << W_SUM) - 64'd1);
   localparam logic [31:0] DIFF_FS = 32'(64'd1 << (W_DIFF - 1));

   typedef struct packed {
      logic [1:0] win;
      logic [1:0] ctr;
      logic       below_lo;
   } tpl_cond_t;

   tpl_cond_t   st;
   tpl_cond_t   next_st;
   logic [31:0] sum_pct;             // intensity times hundred
   logic [31:0] hx_pct;              // |horizontal| times hundred
   logic [31:0] vy_pct;              // |vertical| times hundred
   logic [W_DIFF-1:0] ax;
   logic [W_DIFF-1:0] ay;

   // compare in scaled integers, no division needed
   always_comb begin
      next_st = st;
      ax = cif.hoff[W_DIFF-1] ? (~cif.hoff + 1'b1) : cif.hoff;
      ay = cif.voff[W_DIFF-1] ? (~cif.voff + 1'b1) : cif.voff;
      sum_pct = 32'(cif.sum) * `TPL_PCT_FULL;
      hx_pct  = 32'(ax) * `TPL_PCT_FULL;
      vy_pct  = 32'(ay) * `TPL_PCT_FULL;
      for (int i = 0; i < 2; i++) begin
         // window bounds inclusive
         next_st.win[i] = (sum_pct >= 32'(cif.lo[i]) * SUM_FS) &&
                          (sum_pct <= 32'(cif.hi[i]) * SUM_FS);
         next_st.ctr[i] = (hx_pct < 32'(cif.thr[i]) * DIFF_FS) &&
                          (vy_pct < 32'(cif.thr[i]) * DIFF_FS);
      end
      next_st.below_lo = sum_pct < 32'(cif.lo[0]) * SUM_FS;
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign cif.win      = st.win;
   assign cif.ctr      = st.ctr;
   assign cif.below_lo = st.below_lo;
endmodule
`default_nettype wire

/* hdl/tpl_trigger_port_logic.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tpl_defines.svh"
module tpl_trigger_port_logic
   import tpl_pkg::*;
#(
   parameter int W_SUM  = 12,
   parameter int W_DIFF = 16,
   parameter int W_DRV  = 16
) (
   input  wire logic                     CLK_SYS_IN,
   input  wire logic                     ARST_N_IN,
   input  wire logic [7:0]               ADDR_IN,
   input  wire logic [31:0]              WDATA_IN,
   input  wire logic                     WR_IN,
   input  wire logic                     RD_IN,
   output logic      [31:0]              RDATA_OUT,
   input  wire logic [1:0]               TRIGGER_PORT_IN,
   output logic      [1:0]               TRIGGER_PORT_OUT,
   output logic      [1:0]               TRIGGER_PORT_OE_OUT,
   input  wire logic [W_SUM-1:0]         BEAM_INTENSITY_TOTAL_IN,
   input  wire logic signed [W_DIFF-1:0] HORIZONTAL_OFFSET_IN,
   input  wire logic signed [W_DIFF-1:0] VERTICAL_OFFSET_IN,
   input  wire logic signed [W_DRV-1:0]  X_DEMAND_IN,
   input  wire logic signed [W_DRV-1:0]  Y_DEMAND_IN,
   output logic signed [W_DRV-1:0]       X_DRIVE_OUT,
   output logic signed [W_DRV-1:0]       Y_DRIVE_OUT,
   output logic                          LOOP_CLOSED_OUT,
   output logic                          IRQ_OUT
);
   generate
      if (W_DRV < 2 || W_DRV > 32) begin : g_chk
         $error("drive width must lie in 2..32");
      end
   endgenerate

   // block state apart from the sync and evaluator stages, one register
   typedef struct packed {
      logic [1:0][2:0]         mode;      // function per port
      logic [1:0]              pol;       // 1 = active high
      logic                    auto_open; // auto loop opening enable
      logic                    clear_opt; // 1 = zero drives on open
      logic [1:0]              dout;      // software output bits
      logic [1:0][6:0]         lo;        // lower intensity limits
      logic [1:0][6:0]         hi;        // upper intensity limits
      logic [1:0][6:0]         thr;       // centring thresholds
      tpl_loop_t               loop;      // loop state
      logic signed [W_DRV-1:0] hold_x;    // drives captured at open
      logic signed [W_DRV-1:0] hold_y;
      logic signed [W_DRV-1:0] drv_x;     // applied axis drives
      logic signed [W_DRV-1:0] drv_y;
      logic [3:0]              irq_stat;  // sticky events
      logic [3:0]              irq_mask;  // 1 = enabled
      logic                    irq;       // interrupt line
      logic [31:0]             rdata;     // read answer
      logic [1:0]              pin;       // driven pin levels
      logic [1:0]              oe;        // pin drive enables
   } tpl_state_t;

   tpl_state_t st;
   tpl_state_t next_st;

   logic [1:0] lvl;       // settled pin levels
   logic [1:0] rise;      // settled rising edges
   logic [1:0] fall;      // settled falling edges
   logic [1:0] tog;       // loop toggle requests per port
   logic [1:0] want_lvl;  // level each port should drive
   logic [1:0] want_oe;   // whether each port drives
   logic       sw_close;  // software close command
   logic       sw_open;   // software open command
   logic       tog_par;   // net toggle after both ports
   logic       auto_trip; // intensity dropped while closed
   logic [3:0] ev;        // events this cycle
   logic [3:0] clr;       // write-one-to-clear bits
   tpl_mode_t  new_mode;  // mode being written

   tpl_cond_if #(.W_SUM(W_SUM), .W_DIFF(W_DIFF)) cif ();

   // two-stage synchroniser with edge detect
   tpl_sync #(.N(2)) u_sync (
      .clk_in    (CLK_SYS_IN),
      .arst_n_in (ARST_N_IN),
      .d_in      (TRIGGER_PORT_IN),
      .lvl_out   (lvl),
      .rise_out  (rise),
      .fall_out  (fall)
   );

   // beam condition evaluation, one cycle latency
   tpl_cond #(.W_SUM(W_SUM), .W_DIFF(W_DIFF)) u_cond (
      .clk_in    (CLK_SYS_IN),
      .arst_n_in (ARST_N_IN),
      .cif       (cif)
   );

   // feed measurements and limits to the evaluator
   assign cif.sum  = BEAM_INTENSITY_TOTAL_IN;
   assign cif.hoff = HORIZONTAL_OFFSET_IN;
   assign cif.voff = VERTICAL_OFFSET_IN;
   assign cif.lo   = st.lo;
   assign cif.hi   = st.hi;
   assign cif.thr  = st.thr;

   // per-port function decode
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_port
         logic act;   // port condition true, before polarity
         always_comb begin
            act            = 1'b0;
            want_oe[gi]    = 1'b1;
            tog[gi]        = 1'b0;
            unique case (tpl_mode_t'(st.mode[gi]))
               TPL_MODE_DISABLED,
               TPL_MODE_DIG_IN: begin
                  want_oe[gi] = 1'b0;
               end
               TPL_MODE_TOGGLE: begin
                  want_oe[gi] = 1'b0;
                  // active edge follows polarity
                  tog[gi] = st.pol[gi] ? rise[gi] : fall[gi];
               end
               TPL_MODE_DIG_OUT: begin
                  act = st.dout[gi];
               end
               TPL_MODE_WIN_OUT: begin
                  act = cif.win[gi];
               end
               TPL_MODE_CTR_OUT: begin
                  act = cif.ctr[gi];
               end
               TPL_MODE_BOTH_OUT: begin
                  act = cif.win[gi] & cif.ctr[gi];
               end
               default: begin
                  // unused code behaves as an input
                  want_oe[gi] = 1'b0;
               end
            endcase
            // active high drives act, active low its inverse
            want_lvl[gi] = st.pol[gi] ? act : ~act;
            // released pin: the pull-up lets it read high
            if (!want_oe[gi]) begin
               want_lvl[gi] = 1'b0;
            end
         end
      end
   endgenerate

   // register writes, loop control, events and reads
   always_comb begin
      next_st   = st;
      next_st.rdata = '0;
      sw_close  = 1'b0;
      sw_open   = 1'b0;
      clr       = '0;
      new_mode  = TPL_MODE_DISABLED;
      // register writes
      if (WR_IN) begin
         case (ADDR_IN)
            `TPL_ADDR_CTRL: begin
               for (int i = 0; i < 2; i++) begin
                  new_mode = tpl_mode_t'(WDATA_IN[i*`TPL_CTRL_PORT_W +:
                                                  `TPL_CTRL_MODE_W]);
                  next_st.mode[i] = new_mode;
                  next_st.pol[i]  = WDATA_IN[i*`TPL_CTRL_PORT_W +
                                             `TPL_CTRL_POL_BIT];
                  // start output mode at the inactive level
                  if (new_mode == TPL_MODE_DIG_OUT &&
                      tpl_mode_t'(st.mode[i]) != TPL_MODE_DIG_OUT) begin
                     next_st.dout[i] = 1'b0;
                  end
               end
               next_st.auto_open = WDATA_IN[`TPL_CTRL_AUTO_BIT];
               next_st.clear_opt = WDATA_IN[`TPL_CTRL_CLEAR_BIT];
            end
            `TPL_ADDR_DOUT: begin
               next_st.dout = WDATA_IN[1:0];
            end
            `TPL_ADDR_LIM_ONE, `TPL_ADDR_LIM_TWO: begin
               // software keeps limits in 1..99, not checked here
               for (int i = 0; i < 2; i++) begin
                  if (ADDR_IN == ((i == 0) ? `TPL_ADDR_LIM_ONE
                                           : `TPL_ADDR_LIM_TWO)) begin
                     next_st.lo[i]  = WDATA_IN[`TPL_LIM_LO_LSB +:
                                               `TPL_PCT_W];
                     next_st.hi[i]  = WDATA_IN[`TPL_LIM_HI_LSB +:
                                               `TPL_PCT_W];
                     next_st.thr[i] = WDATA_IN[`TPL_LIM_THR_LSB +:
                                               `TPL_PCT_W];
                  end
               end
            end
            `TPL_ADDR_IRQ_STAT: begin
               clr = WDATA_IN[`TPL_IRQ_W-1:0];
            end
            `TPL_ADDR_IRQ_MASK: begin
               next_st.irq_mask = WDATA_IN[`TPL_IRQ_W-1:0];
            end
            `TPL_ADDR_CMD: begin
               sw_close = WDATA_IN[`TPL_CMD_CLOSE_BIT];
               sw_open  = WDATA_IN[`TPL_CMD_OPEN_BIT];
            end
            default: begin
               // unmapped writes are ignored
            end
         endcase
      end

      // both ports toggling together cancel out
      tog_par   = tog[0] ^ tog[1];
      auto_trip = st.auto_open && cif.below_lo &&
                  st.loop == TPL_LOOP_CLOSED;

      // loop state machine; auto open and software win over toggles
      unique case (st.loop)
         TPL_LOOP_OPEN: begin
            if (!sw_open && (sw_close || tog_par)) begin
               next_st.loop = TPL_LOOP_CLOSED;
            end
         end
         TPL_LOOP_CLOSED: begin
            if (auto_trip || sw_open || (tog_par && !sw_close)) begin
               next_st.loop   = TPL_LOOP_OPEN;
               // capture drives present at the switch
               next_st.hold_x = X_DEMAND_IN;
               next_st.hold_y = Y_DEMAND_IN;
            end
         end
      endcase

      // closed follows the loop; open holds or zeroes
      if (next_st.loop == TPL_LOOP_CLOSED) begin
         next_st.drv_x = X_DEMAND_IN;
         next_st.drv_y = Y_DEMAND_IN;
      end else if (st.clear_opt) begin
         next_st.drv_x = '0;
         next_st.drv_y = '0;
      end else begin
         next_st.drv_x = next_st.hold_x;
         next_st.drv_y = next_st.hold_y;
      end

      // events; a new event beats a same-cycle clear
      ev = '0;
      ev[`TPL_IRQ_TOG_ONE]   = tog[0];
      ev[`TPL_IRQ_TOG_TWO]   = tog[1];
      ev[`TPL_IRQ_AUTO_OPEN] = auto_trip;
      ev[`TPL_IRQ_LOOP_CHG]  = next_st.loop != st.loop;
      next_st.irq_stat = (st.irq_stat & ~clr) | ev;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);

      // pins follow the decoded function
      next_st.pin = want_lvl;
      next_st.oe  = want_oe;

      // reads answer in the following cycle only
      if (RD_IN) begin
         case (ADDR_IN)
            `TPL_ADDR_CTRL: begin
               for (int i = 0; i < 2; i++) begin
                  next_st.rdata[i*`TPL_CTRL_PORT_W +:
                                `TPL_CTRL_MODE_W] = st.mode[i];
                  next_st.rdata[i*`TPL_CTRL_PORT_W +
                                `TPL_CTRL_POL_BIT] = st.pol[i];
               end
               next_st.rdata[`TPL_CTRL_AUTO_BIT]  = st.auto_open;
               next_st.rdata[`TPL_CTRL_CLEAR_BIT] = st.clear_opt;
            end
            `TPL_ADDR_DOUT: begin
               next_st.rdata[1:0] = st.dout;
            end
            `TPL_ADDR_LIM_ONE, `TPL_ADDR_LIM_TWO: begin
               for (int i = 0; i < 2; i++) begin
                  if (ADDR_IN == ((i == 0) ? `TPL_ADDR_LIM_ONE
                                           : `TPL_ADDR_LIM_TWO)) begin
                     next_st.rdata[`TPL_LIM_LO_LSB +:
                                   `TPL_PCT_W] = st.lo[i];
                     next_st.rdata[`TPL_LIM_HI_LSB +:
                                   `TPL_PCT_W] = st.hi[i];
                     next_st.rdata[`TPL_LIM_THR_LSB +:
                                   `TPL_PCT_W] = st.thr[i];
                  end
               end
            end
            `TPL_ADDR_STATUS: begin
               // pin levels as seen, never inverted
               next_st.rdata[1:0] = lvl;
               next_st.rdata[2]   = st.loop == TPL_LOOP_CLOSED;
               next_st.rdata[4:3] = cif.win;
               next_st.rdata[6:5] = cif.ctr;
            end
            `TPL_ADDR_IRQ_STAT: begin
               next_st.rdata[`TPL_IRQ_W-1:0] = st.irq_stat;
            end
            `TPL_ADDR_IRQ_MASK: begin
               next_st.rdata[`TPL_IRQ_W-1:0] = st.irq_mask;
            end
            default: begin
               // unmapped and command reads return zero
            end
         endcase
      end
   end

   // state register; limits come up at their defaults
   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         st     <= '0;
         st.lo  <= {`TPL_RST_LO, `TPL_RST_LO};
         st.hi  <= {`TPL_RST_HI, `TPL_RST_HI};
         st.thr <= {`TPL_RST_THR, `TPL_RST_THR};
      end else begin
         st <= next_st;
      end
   end

   // outputs come straight from the state register
   assign RDATA_OUT           = st.rdata;
   assign TRIGGER_PORT_OUT    = st.pin;
   assign TRIGGER_PORT_OE_OUT = st.oe;
   assign X_DRIVE_OUT         = st.drv_x;
   assign Y_DRIVE_OUT         = st.drv_y;
   assign LOOP_CLOSED_OUT     = st.loop == TPL_LOOP_CLOSED;
   assign IRQ_OUT             = st.irq;
endmodule
`default_nettype wire

/* bench/tpl_ext_eq.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side equipment on the two trigger lines
module tpl_ext_eq (
   input  wire logic [1:0] dut_out_in,  // level the block drives
   input  wire logic [1:0] dut_oe_in,   // block drives the pin
   input  wire logic [1:0] drv_en_in,   // equipment drives the pin
   input  wire logic [1:0] drv_val_in,  // level the equipment drives
   output logic      [1:0] pin_out      // resolved wire level
);
   // block first, then equipment, else the weak pull-up wins
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pin_out[i] = dut_oe_in[i] ? dut_out_in[i] :
                      drv_en_in[i] ? drv_val_in[i] : 1'b1;
      end
   end
endmodule
`default_nettype wire

/* bench/tpl_trigger_port_logic_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tpl_props #(
   parameter int W_DRV = 16
) (
   input wire logic                    CLK_SYS_IN,
   input wire logic                    ARST_N_IN,
   input wire logic [7:0]              ADDR_IN,
   input wire logic                    WR_IN,
   input wire logic                    RD_IN,
   input wire logic [31:0]             RDATA_OUT,
   input wire logic [1:0]              TRIGGER_PORT_IN,
   input wire logic [1:0]              TRIGGER_PORT_OUT,
   input wire logic [1:0]              TRIGGER_PORT_OE_OUT,
   input wire logic signed [W_DRV-1:0] X_DEMAND_IN,
   input wire logic signed [W_DRV-1:0] X_DRIVE_OUT,
   input wire logic                    LOOP_CLOSED_OUT,
   input wire logic                    IRQ_OUT
);
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!ARST_N_IN);
   // read of the command word or past the map
   sequence s_dead_rd;
      RD_IN && ADDR_IN >= 8'h1C;
   endsequence
   // pin moved three edges back, through two sync stages
   sequence s_pin_moved;
      $past(TRIGGER_PORT_IN, 3) != $past(TRIGGER_PORT_IN, 4);
   endsequence
   chk_rdata_idle: assert property (
      !$past(RD_IN) |-> RDATA_OUT == 32'h0) else $error("rdata not idle");
   chk_dead_read: assert property (
      s_dead_rd |=> RDATA_OUT == 32'h0) else $error("dead read not zero");
   chk_released_low: assert property (
      (TRIGGER_PORT_OUT & ~TRIGGER_PORT_OE_OUT) == 2'h0)
      else $error("released pin drives");
   chk_oe_after_wr: assert property (
      $changed(TRIGGER_PORT_OE_OUT) |-> $past(WR_IN, 2))
      else $error("oe moved without write");
   chk_closed_follow: assert property (
      LOOP_CLOSED_OUT && $past(LOOP_CLOSED_OUT)
      |-> X_DRIVE_OUT == $past(X_DEMAND_IN)) else $error("drive not demand");
   chk_open_steady: assert property (
      !$past(LOOP_CLOSED_OUT, 2) && !$past(LOOP_CLOSED_OUT) &&
      !LOOP_CLOSED_OUT && !$past(WR_IN, 2) |-> $stable(X_DRIVE_OUT))
      else $error("open drive moved");
   chk_loop_rise: assert property (
      $rose(LOOP_CLOSED_OUT) |-> ($past(WR_IN) or s_pin_moved))
      else $error("loop closed without cause");
   chk_irq_fall: assert property (
      $fell(IRQ_OUT) |-> $past(WR_IN) || $past(WR_IN, 2))
      else $error("irq dropped without write");
endmodule
bind tpl_trigger_port_logic tpl_props #(.W_DRV(W_DRV)) u_props (
   .CLK_SYS_IN, .ARST_N_IN, .ADDR_IN, .WR_IN, .RD_IN, .RDATA_OUT,
   .TRIGGER_PORT_IN, .TRIGGER_PORT_OUT, .TRIGGER_PORT_OE_OUT,
   .X_DEMAND_IN, .X_DRIVE_OUT, .LOOP_CLOSED_OUT, .IRQ_OUT);
`default_nettype wire

/* bench/tpl_trigger_port_logic_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tpl_trigger_port_logic_test;
   localparam int FS = 4095, FD = 32768; // full scales of sum, offsets
   logic clk, rst_n, wr, rd, loop, irq, wn, ct;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [11:0] sum;
   logic signed [15:0] hoff, voff, xd, yd, xdrv, ydrv;
   logic [1:0] pout, poe, pe, pv, e;
   wire logic [1:0] pin;
   int errors, total_checks, i, m, tv, hv, vv;
   // stimulus table: window edges and centring edges
   logic [11:0] ts [5] = '{12'h199, 12'h19A, 12'hE65, 12'hE66, 12'h7D0};
   logic signed [15:0] hs [5] = '{16'h0CCC, 16'h0CCD, 16'h0, 16'hF334, 16'h0};
   logic signed [15:0] vs [5] = '{16'hF334, 16'h0, 16'hF333, 16'h0CCC, 16'h0};
   tpl_trigger_port_logic dut (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .RDATA_OUT(rdata), .TRIGGER_PORT_IN(pin), .TRIGGER_PORT_OUT(pout),
      .TRIGGER_PORT_OE_OUT(poe), .BEAM_INTENSITY_TOTAL_IN(sum),
      .HORIZONTAL_OFFSET_IN(hoff), .VERTICAL_OFFSET_IN(voff),
      .X_DEMAND_IN(xd), .Y_DEMAND_IN(yd), .X_DRIVE_OUT(xdrv),
      .Y_DRIVE_OUT(ydrv), .LOOP_CLOSED_OUT(loop), .IRQ_OUT(irq));
   tpl_ext_eq u_eq (.dut_out_in(pout), .dut_oe_in(poe), .drv_en_in(pe),
      .drv_val_in(pv), .pin_out(pin));
   // free-running system clock, 40 ns
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, x, s);
      end
   endtask
   // one-cycle write strobe
   task w(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask
   // read strobe, data looked at only in the following cycle
   task rc(input logic [7:0] a, input logic [31:0] k, input logic [31:0] x);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 chk("reg", rdata & k, x);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task pins(input logic [1:0] en, input logic [1:0] v);
      @(posedge clk) begin pe <= en; pv <= v; end
      cyc(5); // two sync stages plus event and state registers
   endtask
   task close_out;
      if (errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog, run needs well under 2000 cycles
   initial begin
      #(40 * 5000);
      errors++;
      close_out;
   end
   // main sequence
   initial begin
      {rst_n, wr, rd, addr, wdata, pe, pv, hoff, voff} = '0;
      sum = 12'h800; xd = 16'h1234; yd = 16'h0F0F;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      chk("oe", 32'(poe), 32'h0);
      rc(8'h10, 32'h7, 32'h3);
      rc(8'h08, 32'h7F7F7F, 32'h0A5A0A);
      rc(8'h20, 32'hFFFFFFFF, 32'h0);
      w(8'h00, 32'h09);
      pins(2'h3, 2'h1);
      rc(8'h10, 32'h3, 32'h1);
      w(8'h00, 32'h01);
      cyc(3);
      rc(8'h10, 32'h3, 32'h1);
      w(8'h00, 32'h2A); // both toggle, one active high, two active low
      w(8'h18, 32'hF);
      pins(2'h1, 2'h0);
      chk("loop", 32'(loop), 32'h0);
      pins(2'h0, 2'h0);
      chk("loop", 32'(loop), 32'h1);
      rc(8'h14, 32'hF, 32'h9);
      chk("irq", 32'(irq), 32'h1);
      w(8'h18, 32'h0);
      cyc(2);
      chk("irq", 32'(irq), 32'h0);
      @(posedge clk) xd <= 16'h7ABC;
      cyc(3);
      chk("xdrv", 32'(xdrv), 32'h7ABC);
      pins(2'h2, 2'h0);
      @(posedge clk) xd <= 16'h0111;
      cyc(3);
      chk("hold", {xdrv, ydrv}, 32'h7ABC0F0F);
      chk("loop", 32'(loop), 32'h0);
      w(8'h00, 32'h22A);
      cyc(3);
      chk("zero", 32'({xdrv, ydrv}), 32'h0);
      pins(2'h0, 2'h0);
      w(8'h00, 32'hB3); // software out, one active low, two active high
      cyc(3);
      chk("pins", 32'({poe, pout}), 32'hD);
      w(8'h04, 32'h3);
      cyc(3);
      chk("pins", 32'({poe, pout}), 32'hE);
      for (m = 0; m < 2; m++) begin
         w(8'h00, m ? 32'h6E : 32'h5C);
         for (i = 0; i < 5; i++) begin
            @(posedge clk) begin sum <= ts[i]; hoff <= hs[i]; voff <= vs[i]; end
            cyc(4);
            tv = ts[i];
            hv = hs[i] < 0 ? -hs[i] : hs[i];
            vv = vs[i] < 0 ? -vs[i] : vs[i];
            wn = tv * 100 >= 10 * FS && tv * 100 <= 90 * FS;
            ct = hv * 100 < 10 * FD && vv * 100 < 10 * FD;
            e = m ? {~(wn & ct), wn & ct} : {~ct, wn};
            chk("cond", 32'(pout), 32'(e));
         end
      end
      w(8'h00, 32'h107); // one unused code, two disabled, auto open on
      cyc(3);
      chk("oe", 32'(poe), 32'h0);
      @(posedge clk) sum <= 12'h800;
      w(8'h14, 32'hF);
      w(8'h18, 32'h4);
      w(8'h1C, 32'h1);
      cyc(2);
      chk("loop", 32'(loop), 32'h1);
      @(posedge clk) sum <= 12'h199;
      cyc(4);
      chk("auto", 32'({loop, irq}), 32'h1);
      rc(8'h1C, 32'hFFFFFFFF, 32'h0);
      w(8'h14, 32'hF);
      cyc(2);
      chk("irq", 32'(irq), 32'h0);
      // software close, then status with loop and both conditions
      @(posedge clk) sum <= 12'h800;
      w(8'h1C, 32'h1);
      rc(8'h10, 32'h7C, 32'h7C);
      w(8'h1C, 32'h2);
      cyc(2);
      chk("loop", 32'(loop), 32'h0);
      w(8'h0C, 32'h0B5C09);
      rc(8'h0C, 32'h7F7F7F, 32'h0B5C09);
      close_out;
   end
endmodule
`default_nettype wire
